// ### core/bcr_pkg.sv
// constants and types shared by the configuration register bank
package bcr_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned WDOG_UNIT_MS   = 2;
  localparam int unsigned WDOG_UNIT_CYC  = WDOG_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HOLD_UNIT_NS   = 40;
  localparam int unsigned HOLD_UNIT_CYC  = (HOLD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_UNIT_NS = 5;

  // widths
  localparam int unsigned ADR_W   = 8;
  localparam int unsigned CNT_W   = 6;
  localparam int unsigned PRESC_W = 18;

  // register indices; byte address is four times the index
  localparam logic [5:0] REG_SELFTEST_IDX = 6'h14;
  localparam logic [5:0] REG_VSEL_IDX     = 6'h15;
  localparam logic [5:0] REG_WDOG_IDX     = 6'h16;
  localparam logic [5:0] REG_CBUS_IDX     = 6'h17;

  // reset values
  localparam logic [7:0] SELFTEST_RST = 8'h00;
  localparam logic [7:0] VSEL_RST     = 8'h01;
  localparam logic [7:0] WDOG_RST     = 8'hFE;
  localparam logic [7:0] CBUS_RST     = 8'h1E;

  // voltage select write keys
  localparam logic [7:0] VSEL_KEY_SET = 8'hB5;
  localparam logic [7:0] VSEL_KEY_CLR = 8'hB6;

  // field positions
  localparam int unsigned ST_EN_BIT     = 0;
  localparam int unsigned ST_SRC_LSB    = 1;
  localparam logic [7:0]  ST_WR_MASK    = 8'h07;
  localparam int unsigned WD_DIS_BIT    = 0;
  localparam int unsigned WD_TO_LSB     = 1;
  localparam int unsigned CB_PASS_BIT   = 7;
  localparam int unsigned CB_HOLD_LSB   = 4;
  localparam int unsigned CB_DEPTH_LSB  = 0;

  // oscillator source codes
  localparam logic [1:0] SRC_CODE_00 = 2'h0;
  localparam logic [1:0] SRC_CODE_01 = 2'h1;
  localparam logic [1:0] SRC_CODE_10 = 2'h2;
  localparam logic [1:0] SRC_CODE_11 = 2'h3;

  // strap settle cycles after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // selected clock sources
  typedef enum logic [2:0] {
    BCR_SRC_VIDEO,
    BCR_SRC_EXT_PIXEL,
    BCR_SRC_OSC25,
    BCR_SRC_OSC33,
    BCR_SRC_OSC50,
    BCR_SRC_OSC100
  } bcr_clk_src_t;

endpackage

// ### core/bcr_pin_filter.sv
// glitch filter and hold delay for one control bus input pin
`timescale 1ns/1ps
`default_nettype none
module bcr_pin_filter
  import bcr_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // pin and filtered level
  input  wire logic                      pin_i,
  input  wire logic [bcr_pkg::CNT_W-1:0] need_i,
  output logic                           level_o
);

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    logic             lvl;
    logic [CNT_W-1:0] cnt;
  } bcr_flt_t;

  bcr_flt_t q;
  bcr_flt_t d;

  // accept a new level once it stood for need_i agreeing cycles
  always_comb
  begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3 && q.s3 != q.lvl)
    begin
      if (q.cnt >= need_i)
      begin
        d.lvl = q.s3;
        d.cnt = '0;
      end
      else
      begin
        d.cnt = CNT_W'(q.cnt + 1'b1);
      end
    end
    else
    begin
      d.cnt = '0;  // glitch rejected, restart
    end
  end

  // state register, idle bus level is high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, cnt: '0};
    else
      q <= d;
  end

  assign level_o = q.lvl;

  a_filter_min_width : assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(q.lvl) |-> $past(q.cnt) >= $past(need_i))
    else $error("filtered level changed before input was stable long enough");

endmodule
`default_nettype wire

// ### core/bcr_regs.sv
// self-test clock, bus voltage, watchdog and control bus configuration registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - oscillator override: codes pick 50/50/100/25 MHz
// - self-test enable: 00 pixel, 01 33, 1x 100
// - strap low gives 3.3V, high 1.8V
// - digital reset forces 3.3V selection
// - voltage read: 0 is 1.8V, 1 is 3.3V
// - key 0xB5 sets, 0xB6 clears selection
// - watchdog terminates overlong channel transactions
// - timeout is field times 2 ms
// - watchdog runs while disable bit is zero
// - default: forward only remote deserializer/target IDs
// - forward-all: forward every non-own target address
// - SDA hold time in 40 ns units
// - glitch rejection width in 5 ns units
module bcr_regs
  import bcr_pkg::*;
#(
  parameter int unsigned WDOG_UNIT_CYC = bcr_pkg::WDOG_UNIT_CYC
)
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone slave
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [bcr_pkg::ADR_W-1:0] adr_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic [31:0]               dat_i,
  output logic      [31:0]               dat_o,
  output logic                           ack_o,
  // strap and device state
  input  wire logic                      vsel_strap_i,
  input  wire logic                      digital_reset_i,
  input  wire logic                      video_clk_present_i,
  input  wire logic                      osc_override_i,
  // clock source selection
  output bcr_pkg::bcr_clk_src_t          frame_clk_src_o,
  output bcr_pkg::bcr_clk_src_t          test_clk_src_o,
  output logic                           selftest_en_o,
  output logic                           bus_voltage_select_o,
  // bidir_control_channel watchdog
  input  wire logic                      xact_start_i,
  input  wire logic                      xact_done_i,
  output logic                           xact_abort_o,
  // pass-through forwarding
  input  wire logic                      target_valid_i,
  input  wire logic [6:0]                target_addr_i,
  input  wire logic [6:0]                own_id_i,
  input  wire logic [6:0]                remote_deser_id_i,
  input  wire logic [6:0]                remote_target_id_i,
  output logic                           fwd_valid_o,
  output logic                           fwd_o,
  // control bus pins, filtered
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           scl_filt_o,
  output logic                           sda_filt_o
);

  import bcr_pkg::*;

  typedef struct packed {
    logic               ack;
    logic [31:0]        dat;
    logic [7:0]         st;
    logic               vsel;
    logic [7:0]         wd;
    logic [7:0]         cb;
    logic               s1;
    logic               s2;
    logic               s3;
    logic               strap_done;
    logic [1:0]         strap_wait;
    bcr_clk_src_t       frame_src;
    bcr_clk_src_t       test_src;
    logic               wd_active;
    logic [PRESC_W-1:0] wd_presc;
    logic [6:0]         wd_units;
    logic               abort;
    logic               fwd_valid;
    logic               fwd;
  } bcr_state_t;

  bcr_state_t       q;
  bcr_state_t       d;
  logic             req;
  logic             strap_take;
  logic [7:0]       rd_byte;
  logic [CNT_W-1:0] glitch_cyc;
  logic [CNT_W-1:0] hold_cyc;
  logic [CNT_W-1:0] need [2];
  logic [1:0]       pins;
  logic [1:0]       filt;

  assign req = cyc_i & stb_i & ~q.ack;

  // next state of the whole register bank
  always_comb
  begin
    d            = q;
    d.ack        = 1'b0;
    d.abort      = 1'b0;
    d.fwd_valid  = 1'b0;
    strap_take   = 1'b0;
    rd_byte      = 8'h00;
    // strap synchroniser
    d.s1 = vsel_strap_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // strap capture once settled after reset release
    if (!q.strap_done)
    begin
      if (q.strap_wait == STRAP_SETTLE && q.s2 == q.s3)
      begin
        strap_take   = 1'b1;
        d.vsel       = ~q.s3;
        d.strap_done = 1'b1;
      end
      else if (q.strap_wait != STRAP_SETTLE)
      begin
        d.strap_wait = 2'(q.strap_wait + 1'b1);
      end
    end
    // wishbone read and write, one cycle answer
    if (req)
    begin
      d.ack = 1'b1;
      case (adr_i[7:2])
        REG_SELFTEST_IDX: rd_byte = q.st & ST_WR_MASK;
        REG_VSEL_IDX:     rd_byte = {7'h00, q.vsel};
        REG_WDOG_IDX:     rd_byte = q.wd;
        REG_CBUS_IDX:     rd_byte = q.cb;
        default:          rd_byte = 8'h00;
      endcase
      d.dat = {24'h000000, rd_byte};
      if (we_i && sel_i[0])
      begin
        case (adr_i[7:2])
          REG_SELFTEST_IDX: d.st = dat_i[7:0] & ST_WR_MASK;
          REG_VSEL_IDX:
          begin
            if (dat_i[7:0] == VSEL_KEY_SET)
              d.vsel = 1'b1;
            else if (dat_i[7:0] == VSEL_KEY_CLR)
              d.vsel = 1'b0;
            else
              d.vsel = d.vsel;  // other values ignored
          end
          REG_WDOG_IDX:     d.wd = dat_i[7:0];
          REG_CBUS_IDX:     d.cb = dat_i[7:0];
          default:          d.st = d.st;
        endcase
      end
    end
    // digital reset wins over strap and keys
    if (digital_reset_i)
    begin
      d.vsel       = 1'b1;
      d.strap_done = 1'b1;
    end
    // frame oscillator choice
    d.frame_src = BCR_SRC_VIDEO;
    if (!q.st[ST_EN_BIT] && !video_clk_present_i && osc_override_i)
    begin
      case (q.st[ST_SRC_LSB +: 2])
        SRC_CODE_10: d.frame_src = BCR_SRC_OSC100;
        SRC_CODE_11: d.frame_src = BCR_SRC_OSC25;
        default:     d.frame_src = BCR_SRC_OSC50;
      endcase
    end
    // self-test clock choice
    d.test_src = BCR_SRC_VIDEO;
    if (q.st[ST_EN_BIT])
    begin
      case (q.st[ST_SRC_LSB +: 2])
        SRC_CODE_00: d.test_src = BCR_SRC_EXT_PIXEL;
        SRC_CODE_01: d.test_src = BCR_SRC_OSC33;
        default:     d.test_src = BCR_SRC_OSC100;
      endcase
    end
    // transaction watchdog
    if (q.wd[WD_DIS_BIT])
    begin
      d.wd_active = 1'b0;
    end
    else if (xact_start_i)
    begin
      d.wd_active = 1'b1;
      d.wd_presc  = '0;
      d.wd_units  = '0;
    end
    else if (xact_done_i)
    begin
      d.wd_active = 1'b0;
    end
    else if (q.wd_active)
    begin
      if (q.wd_presc == PRESC_W'(WDOG_UNIT_CYC - 1))
      begin
        d.wd_presc = '0;
        d.wd_units = 7'(q.wd_units + 1'b1);
        if (8'(q.wd_units) + 8'h01 >= {1'b0, q.wd[WD_TO_LSB +: 7]})
        begin
          d.abort     = 1'b1;
          d.wd_active = 1'b0;
        end
      end
      else
      begin
        d.wd_presc = PRESC_W'(q.wd_presc + 1'b1);
      end
    end
    // pass-through forwarding decision
    if (target_valid_i)
    begin
      d.fwd_valid = 1'b1;
      if (q.cb[CB_PASS_BIT])
        d.fwd = (target_addr_i != own_id_i);
      else
        d.fwd = (target_addr_i == remote_deser_id_i) || (target_addr_i == remote_target_id_i);
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q            <= '0;
      q.st         <= SELFTEST_RST;
      q.vsel       <= VSEL_RST[0];
      q.wd         <= WDOG_RST;
      q.cb         <= CBUS_RST;
      q.s1         <= 1'b0;
      q.frame_src  <= BCR_SRC_VIDEO;
      q.test_src   <= BCR_SRC_VIDEO;
    end
    else
    begin
      q <= d;
    end
  end

  // filter depths in cycles for scl (0) and sda (1)
  assign glitch_cyc = CNT_W'((32'(q.cb[CB_DEPTH_LSB +: 4]) * GLITCH_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  assign hold_cyc   = CNT_W'(32'(q.cb[CB_HOLD_LSB +: 3]) * HOLD_UNIT_CYC);
  assign need[0]    = glitch_cyc;
  assign need[1]    = CNT_W'(glitch_cyc + hold_cyc);
  assign pins       = {sda_i, scl_i};

  // one filter per control bus pin
  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    bcr_pin_filter u_flt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (pins[g]),
      .need_i  (need[g]),
      .level_o (filt[g])
    );
  end

  // outputs
  assign ack_o                = q.ack;
  assign dat_o                = q.dat;
  assign frame_clk_src_o      = q.frame_src;
  assign test_clk_src_o       = q.test_src;
  assign selftest_en_o        = q.st[ST_EN_BIT];
  assign bus_voltage_select_o = q.vsel;
  assign xact_abort_o         = q.abort;
  assign fwd_valid_o          = q.fwd_valid;
  assign fwd_o                = q.fwd;
  assign scl_filt_o           = filt[0];
  assign sda_filt_o           = filt[1];

  default clocking cb_clk @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_bus_ack_once : assert property (req |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle ack");
  a_strap_capture : assert property (strap_take && !digital_reset_i |=> bus_voltage_select_o == !$past(q.s3))
    else $error("strap level not inverted into voltage select");
  a_vsel_dig_reset : assert property (digital_reset_i |=> bus_voltage_select_o ##1 $stable(q.strap_done))
    else $error("digital reset did not force 3.3V");
  a_vsel_read_back : assert property (req && !we_i && adr_i[7:2] == REG_VSEL_IDX |=> dat_o == {31'h0, $past(q.vsel)})
    else $error("voltage select read wrong");
  a_vsel_key_clr : assert property (req && we_i && sel_i[0] && adr_i[7:2] == REG_VSEL_IDX && dat_i[7:0] == VSEL_KEY_CLR
    && !digital_reset_i && q.strap_done |=> !bus_voltage_select_o)
    else $error("clear key not applied");
  a_vsel_bad_key : assert property (req && we_i && adr_i[7:2] == REG_VSEL_IDX && dat_i[7:0] != VSEL_KEY_SET
    && dat_i[7:0] != VSEL_KEY_CLR && !digital_reset_i && q.strap_done |=> $stable(bus_voltage_select_o))
    else $error("non-key write changed voltage select");
  a_frame_osc_25 : assert property (!q.st[ST_EN_BIT] && q.st[2:1] == SRC_CODE_11 && !video_clk_present_i
    && osc_override_i |=> frame_clk_src_o == BCR_SRC_OSC25)
    else $error("frame oscillator code 11 not 25 MHz");
  a_test_osc_33 : assert property (q.st[ST_EN_BIT] && q.st[2:1] == SRC_CODE_01 |=> test_clk_src_o == BCR_SRC_OSC33)
    else $error("self-test code 01 not 33 MHz");
  a_wdog_timeout : assert property (q.wd_active && !q.wd[WD_DIS_BIT] && !xact_start_i && !xact_done_i
    && q.wd_presc == PRESC_W'(WDOG_UNIT_CYC - 1) && q.wd_units + 7'h01 == q.wd[7:1] |=> xact_abort_o ##1 !xact_abort_o)
    else $error("watchdog did not abort at timeout");
  a_wdog_disabled : assert property (q.wd[WD_DIS_BIT] |=> !xact_abort_o && !q.wd_active)
    else $error("disabled watchdog still active");
  a_wdog_restart : assert property (xact_start_i && !q.wd[WD_DIS_BIT] |=> q.wd_active && q.wd_units == 7'h00)
    else $error("watchdog did not restart");
  a_fwd_match : assert property (target_valid_i && !q.cb[CB_PASS_BIT] && target_addr_i == remote_deser_id_i
    |=> fwd_valid_o && fwd_o)
    else $error("matching remote id not forwarded");
  a_fwd_own : assert property (target_valid_i && q.cb[CB_PASS_BIT] && target_addr_i == own_id_i |=> fwd_valid_o && !fwd_o)
    else $error("own address forwarded");

  c_key_set : cover property (req && we_i && adr_i[7:2] == REG_VSEL_IDX && dat_i[7:0] == VSEL_KEY_SET);
  c_abort : cover property (xact_abort_o);
  c_fwd_all : cover property (fwd_valid_o && fwd_o && q.cb[CB_PASS_BIT]);
  c_selftest : cover property (selftest_en_o && test_clk_src_o == BCR_SRC_EXT_PIXEL);

endmodule
`default_nettype wire

// ### verif/bcr_host_model.sv
// wishbone host model issuing single register accesses
`timescale 1ns/1ps
`default_nettype none
module bcr_host_model
(
  // clock
  input  wire logic        clk_i,
  // wishbone master side
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic        ack_i,
  // status
  output logic             timeout_o
);
  // bus idle at time zero
  initial
  begin
    {cyc_o, stb_o, we_o, timeout_o} = 4'h0;
    {adr_o, sel_o, dat_o} = '0;
  end

  // one classic cycle, held until ack is sampled or 32 cycles pass
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 32);
    timeout_o <= (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released lines show no stale value
    we_o  <= ~w;
    adr_o <= ~a;
    sel_o <= 4'h0;
    dat_o <= ~{24'h0, d};
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### verif/bcr_regs_tb.sv
// self-checking testbench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module bcr_regs_tb;
  import bcr_pkg::*;
  localparam int unsigned UNIT = 20;
  logic clk_i = 0, rst_i = 1, cyc_i, stb_i, we_i, ack_o, host_to;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic vsel_strap_i = 1, digital_reset_i = 0, video_clk_present_i = 0, osc_override_i = 1;
  bcr_clk_src_t frame_clk_src_o, test_clk_src_o;
  logic selftest_en_o, bus_voltage_select_o, xact_start_i = 0, xact_done_i = 0, xact_abort_o;
  logic target_valid_i = 0, fwd_valid_o, fwd_o, scl_i = 1, sda_i = 1, scl_filt_o, sda_filt_o;
  logic [6:0] target_addr_i = 0, own_id_i = 0, remote_deser_id_i = 0, remote_target_id_i = 0;
  logic [7:0] rd_q[$];
  logic fwd_q[$];
  int error_cnt = 0, total_checks = 0, n, t, k;
  logic sl, dl, fe;
  bcr_clk_src_t ef, et;

  always #5 clk_i = ~clk_i;

  bcr_host_model host (.clk_i, .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
    .dat_o(dat_i), .ack_i(ack_o), .timeout_o(host_to));
  bcr_regs #(.WDOG_UNIT_CYC(UNIT)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .vsel_strap_i, .digital_reset_i, .video_clk_present_i, .osc_override_i,
    .frame_clk_src_o, .test_clk_src_o, .selftest_en_o, .bus_voltage_select_o, .xact_start_i,
    .xact_done_i, .xact_abort_o, .target_valid_i, .target_addr_i, .own_id_i, .remote_deser_id_i,
    .remote_target_id_i, .fwd_valid_o, .fwd_o, .scl_i, .sda_i, .scl_filt_o, .sda_filt_o);

  // results are matched against the oldest note
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0)
      `CHK("read data", {24'h000000, rd_q.pop_front()}, dat_o)
    if (fwd_valid_o === 1'b1 && fwd_q.size() > 0)
      `CHK("forward decision", fwd_q.pop_front(), fwd_o)
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_to();
    if (host_to === 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
    chk_to();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    host.access(1'b0, a, 8'h00);
    chk_to();
  endtask

  // one-cycle pulse: 0 digital reset, 1 start, 2 done
  task automatic pulse(input int w);
    case (w)
      0: digital_reset_i <= 1'b1;
      1: xact_start_i <= 1'b1;
      default: xact_done_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {digital_reset_i, xact_start_i, xact_done_i} <= 3'h0;
  endtask

  // cycles until abort pulse, lim when none
  task automatic watch(input int lim, output int c);
    c = 0;
    do
    begin
      @(posedge clk_i);
      c++;
    end while (xact_abort_o !== 1'b1 && c < lim);
  endtask

  // both pins low for len cycles, note if filtered levels dropped
  task automatic glitch(input int len, output logic s, output logic d);
    s = 0;
    d = 0;
    scl_i <= 1'b0;
    sda_i <= 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk_i);
      if (i == len - 1) {scl_i, sda_i} <= 2'h3;
      s |= (scl_filt_o === 1'b0);
      d |= (sda_filt_o === 1'b0);
    end
  endtask

  initial
  begin
    n = $urandom(30824);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    // reset values, strap high captured as 1.8V, unmapped place
    rd(8'h50, SELFTEST_RST);
    rd(8'h54, 8'h00);
    rd(8'h58, WDOG_RST);
    rd(8'h5C, CBUS_RST);
    wr(8'h60, 8'hFF);
    rd(8'h60, 8'h00);
    `CHK("vsel out", 1'b0, bus_voltage_select_o)
    // keys, ignored writes, digital reset
    wr(8'h54, VSEL_KEY_SET);
    rd(8'h54, 8'h01);
    wr(8'h54, 8'h5A);
    rd(8'h54, 8'h01);
    wr(8'h54, VSEL_KEY_CLR);
    rd(8'h54, 8'h00);
    wr(8'h54, 8'h01);
    rd(8'h54, 8'h00);
    pulse(0);
    repeat (2) @(posedge clk_i);
    `CHK("vsel out", 1'b1, bus_voltage_select_o)
    rd(8'h54, 8'h01);
    // every source code with self-test off and on
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h50, c[7:0]);
      repeat (2) @(posedge clk_i);
      ef = c[0] ? BCR_SRC_VIDEO : (c[2:1] == 2'h2 ? BCR_SRC_OSC100 : c[2:1] == 2'h3 ? BCR_SRC_OSC25 : BCR_SRC_OSC50);
      et = !c[0] ? BCR_SRC_VIDEO : (c[2] ? BCR_SRC_OSC100 : c[1] ? BCR_SRC_OSC33 : BCR_SRC_EXT_PIXEL);
      `CHK("frame src", ef, frame_clk_src_o)
      `CHK("test src", et, test_clk_src_o)
      `CHK("selftest en", c[0], selftest_en_o)
    end
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h07);
    video_clk_present_i <= 1'b1;
    wr(8'h50, 8'h04);
    repeat (2) @(posedge clk_i);
    `CHK("frame src", BCR_SRC_VIDEO, frame_clk_src_o)
    // watchdog: lowest and random timeout field, never zero
    for (int i = 0; i < 2; i++)
    begin
      t = i ? 2 + $urandom % 3 : 1;
      wr(8'h58, {t[6:0], 1'b0});
      pulse(1);
      watch(200, n);
      `CHK("abort time", 1'b1, (n >= t * UNIT + 1 && n <= t * UNIT + 3))
    end
    pulse(1);
    repeat (10) @(posedge clk_i);
    pulse(1);
    watch(200, n);
    `CHK("abort after restart", 1'b1, (n >= t * UNIT + 1 && n <= t * UNIT + 3))
    pulse(1);
    repeat (5) @(posedge clk_i);
    pulse(2);
    watch(6 * UNIT, n);
    `CHK("abort after done", 6 * UNIT, n)
    wr(8'h58, 8'h03);
    pulse(1);
    watch(4 * UNIT, n);
    `CHK("abort disabled", 4 * UNIT, n)
    // forwarding, matched and other addresses, back to back
    {own_id_i, remote_deser_id_i, remote_target_id_i} <= {7'h12, 7'h34, 7'h56};
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h5C, m ? 8'h9E : 8'h1E);
      for (int i = 0; i < 16; i++)
      begin
        k = $urandom % 4;
        target_addr_i <= k == 0 ? 7'h34 : k == 1 ? 7'h56 : k == 2 ? 7'h12 : 7'($urandom);
        target_valid_i <= 1'b1;
        @(posedge clk_i);
        fe = m ? (target_addr_i != 7'h12) : (target_addr_i == 7'h34 || target_addr_i == 7'h56);
        fwd_q.push_back(fe);
      end
      target_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    // hold 2 units, no depth: short pulse passes scl, not sda
    wr(8'h5C, 8'h20);
    glitch(5, sl, dl);
    `CHK("scl glitch seen", 1'b1, sl)
    `CHK("sda glitch seen", 1'b0, dl)
    glitch(30, sl, dl);
    `CHK("sda long low seen", 1'b1, dl)
    // depth 14 units: 3 cycle pulse rejected
    wr(8'h5C, 8'h0E);
    glitch(3, sl, dl);
    `CHK("scl filtered", 1'b0, sl)
    repeat (4) @(posedge clk_i);
    `CHK("notes left", 0, rd_q.size() + fwd_q.size())
    tally_and_finish();
  end
endmodule
`default_nettype wire
